/* crx_params.svh */
// Purpose: constants of the crtc vertical and start address extension
// Assumes: indexed i/o access, index port then data port
// Notes: offsets are crtc index values
`ifndef CRX_PARAMS_SVH
`define CRX_PARAMS_SVH
`define CRX_IO_IDX_MONO 16'h03b4
`define CRX_IO_DAT_MONO 16'h03b5
`define CRX_IO_IDX_COL 16'h03d4
`define CRX_IO_DAT_COL 16'h03d5
`define CRX_IDX_VDE_HI 8'h31
`define CRX_IDX_VSS_HI 8'h32
`define CRX_IDX_VBS_HI 8'h33
`define CRX_IDX_SA_UPD 8'h40
`define CRX_IDX_OFS_HI 8'h41
`define CRX_UPD_BIT 7
`define CRX_NIB_RST 4'h0
`define CRX_IDX_RST 8'h00
`define CRX_REQ_RST 1'b0
`endif

/* crx_pkg.sv */
// Purpose: shared types of the crtc extension block
// Assumes: nothing
// Notes: widths fixed by the widest extended value
package crx_pkg;
  typedef logic [11:0] crx_line_t;
  typedef logic [19:0] crx_addr_t;
  typedef logic [11:0] crx_ofs_t;
  typedef enum logic {
    CRX_COMPAT = 1'b0,
    CRX_EXT = 1'b1
  } crx_mode_t;
endpackage : crx_pkg

/* crx_ext.sv */
// Purpose: extended vertical compares, start address and row offset
// Assumes: base crtc bytes arrive as same-clock inputs
// Notes: line counter stepped by the base horizontal timing
`timescale 1ns/100ps
`include "crx_params.svh"
module crx_ext #(
  parameter int LINE_W = 12
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  input wire crx_pkg::crx_mode_t i_ext_mode,
  input wire logic [7:0] i_display_end_low_byte,
  input wire logic [7:0] i_vertical_overflow_bits,
  input wire logic [7:0] i_sync_start_low_byte,
  input wire logic [7:0] i_blank_start_low_byte,
  input wire logic [7:0] i_max_scan_line_reg,
  input wire logic [7:0] i_start_address_high_byte,
  input wire logic [7:0] i_start_address_low_byte,
  input wire logic [7:0] i_row_offset_low_byte,
  input wire logic i_offset_dword,
  input wire logic i_line_tick,
  input wire logic i_frame_restart,
  output crx_pkg::crx_line_t o_line,
  output logic o_vdisp_active,
  output logic o_vsync_begin,
  output logic o_vblank_begin,
  output crx_pkg::crx_line_t o_display_end,
  output crx_pkg::crx_line_t o_sync_start,
  output crx_pkg::crx_line_t o_blank_start,
  output crx_pkg::crx_addr_t o_start_addr,
  output crx_pkg::crx_ofs_t o_row_offset,
  output logic [13:0] o_row_pitch_bytes
);
  import crx_pkg::*;

  generate
    if (LINE_W != 12) begin : g_bad_width
      $error("crx_ext: LINE_W must be 12");
    end
  endgenerate

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // compat keeps two top bits, extended keeps the nibble
  function automatic crx_line_t fmt_line(
    input crx_mode_t mode,
    input logic [3:0] nib,
    input logic b9,
    input logic b8,
    input logic [7:0] low
  );
    crx_line_t r;
    r = {2'b00, b9, b8, low};
    if (mode == CRX_EXT) begin
      r = {nib, low};
    end
    return r;
  endfunction : fmt_line

  // ----------------------------------------
  // indexed register port
  // ----------------------------------------
  logic [7:0] idx;
  logic [3:0] vde_nib;
  logic [3:0] vss_nib;
  logic [3:0] vbs_nib;
  logic [3:0] sa_nib;
  logic [3:0] ofs_nib;
  logic req;
  logic idx_hit;
  logic dat_hit;
  logic wr_dat;
  logic wr_sa;
  logic [7:0] rd_val;

  assign idx_hit = (i_io_addr == `CRX_IO_IDX_MONO) ||
                   (i_io_addr == `CRX_IO_IDX_COL);
  assign dat_hit = (i_io_addr == `CRX_IO_DAT_MONO) ||
                   (i_io_addr == `CRX_IO_DAT_COL);
  assign wr_dat = i_io_wr && dat_hit;
  assign wr_sa = wr_dat && (idx == `CRX_IDX_SA_UPD);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idx <= `CRX_IDX_RST;
    end else if (i_io_wr && idx_hit) begin
      idx <= i_io_wdata;
    end
  end

  // reserved bits 7-4 are not stored here (bit 7 at index 40h sets req instead), software keeps them zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vde_nib <= `CRX_NIB_RST;
      vss_nib <= `CRX_NIB_RST;
      vbs_nib <= `CRX_NIB_RST;
      sa_nib <= `CRX_NIB_RST;
      ofs_nib <= `CRX_NIB_RST;
    end else if (wr_dat) begin
      case (idx)
        `CRX_IDX_VDE_HI: vde_nib <= i_io_wdata[3:0];
        `CRX_IDX_VSS_HI: vss_nib <= i_io_wdata[3:0];
        `CRX_IDX_VBS_HI: vbs_nib <= i_io_wdata[3:0];
        `CRX_IDX_SA_UPD: sa_nib <= i_io_wdata[3:0];
        `CRX_IDX_OFS_HI: ofs_nib <= i_io_wdata[3:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_val = 8'h00;
    case (idx)
      `CRX_IDX_VDE_HI: rd_val = {4'h0, vde_nib};
      `CRX_IDX_VSS_HI: rd_val = {4'h0, vss_nib};
      `CRX_IDX_VBS_HI: rd_val = {4'h0, vbs_nib};
      `CRX_IDX_SA_UPD: rd_val = {req, 3'h0, sa_nib};
      `CRX_IDX_OFS_HI: rd_val = {4'h0, ofs_nib};
      default: rd_val = 8'h00;
    endcase
  end

  // index port reads back the index; unmapped reads give zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_io_rdata <= 8'h00;
    end else if (i_io_rd && idx_hit) begin
      o_io_rdata <= idx;
    end else if (i_io_rd && dat_hit) begin
      o_io_rdata <= rd_val;
    end
  end

  // ----------------------------------------
  // assembled vertical values
  // ----------------------------------------
  crx_line_t de_val;
  crx_line_t vss_val;
  crx_line_t vbs_val;

  always_comb begin
    de_val = fmt_line(i_ext_mode, vde_nib, i_vertical_overflow_bits[6],
      i_vertical_overflow_bits[1], i_display_end_low_byte);
    vss_val = fmt_line(i_ext_mode, vss_nib, i_vertical_overflow_bits[7],
      i_vertical_overflow_bits[2], i_sync_start_low_byte);
    vbs_val = fmt_line(i_ext_mode, vbs_nib, i_max_scan_line_reg[5],
      i_vertical_overflow_bits[3], i_blank_start_low_byte);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_display_end <= '0;
      o_sync_start <= '0;
      o_blank_start <= '0;
    end else begin
      o_display_end <= de_val;
      o_sync_start <= vss_val;
      o_blank_start <= vbs_val;
    end
  end

  // ----------------------------------------
  // scan line counter and compares
  // ----------------------------------------
  crx_line_t next_line;
  logic line_step;
  logic vs_hit;
  logic vb_hit;

  // restart marks the first active line, so all compares count from it
  always_comb begin
    next_line = o_line;
    if (i_frame_restart) begin
      next_line = '0;
    end else if (i_line_tick) begin
      next_line = o_line + 12'h001;
    end
  end

  assign line_step = i_frame_restart || i_line_tick;
  assign vs_hit = line_step && (next_line == vss_val);
  assign vb_hit = line_step && (next_line == vbs_val);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_line <= '0;
    end else begin
      o_line <= next_line;
    end
  end

  // display end names the last active line, hence less-or-equal
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_vdisp_active <= 1'b0;
      o_vsync_begin <= 1'b0;
      o_vblank_begin <= 1'b0;
    end else begin
      o_vdisp_active <= (next_line <= de_val);
      o_vsync_begin <= vs_hit;
      o_vblank_begin <= vb_hit;
    end
  end

  // ----------------------------------------
  // start address
  // ----------------------------------------
  logic xfer;
  crx_addr_t sa_ext;
  crx_addr_t sa_compat;

  assign xfer = vs_hit && (i_ext_mode == CRX_EXT) && req;
  assign sa_ext = {sa_nib, i_start_address_high_byte,
                   i_start_address_low_byte};
  assign sa_compat = {4'h0, i_start_address_high_byte,
                      i_start_address_low_byte};

  // a software write beats the hardware clear in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req <= `CRX_REQ_RST;
    end else if (wr_sa) begin
      req <= i_io_wdata[`CRX_UPD_BIT];
    end else if (xfer) begin
      req <= 1'b0;
    end
  end

  // compat also loads only at vsync, so mid-frame writes never tear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_start_addr <= '0;
    end else if (xfer) begin
      o_start_addr <= sa_ext;
    end else if (vs_hit && (i_ext_mode == CRX_COMPAT)) begin
      o_start_addr <= sa_compat;
    end
  end

  // ----------------------------------------
  // row offset
  // ----------------------------------------
  crx_ofs_t ofs_val;

  always_comb begin
    ofs_val = {4'h0, i_row_offset_low_byte};
    if (i_ext_mode == CRX_EXT) begin
      ofs_val = {ofs_nib, i_row_offset_low_byte};
    end
  end

  // pitch in bytes: two per word, four per doubleword
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_row_offset <= '0;
      o_row_pitch_bytes <= 14'h0000;
    end else begin
      o_row_offset <= ofs_val;
      if (i_offset_dword) begin
        o_row_pitch_bytes <= {ofs_val, 2'b00};
      end else begin
        o_row_pitch_bytes <= {1'b0, ofs_val, 1'b0};
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_de_compat;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ext_mode == CRX_COMPAT) |=> o_display_end ==
      {2'b00, $past(i_vertical_overflow_bits[6]),
       $past(i_vertical_overflow_bits[1]), $past(i_display_end_low_byte)};
  endproperty
  a_de_compat: assert property (p_de_compat) else $error("compat display end wrong");
  property p_de_ext;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ext_mode == CRX_EXT) |=> o_display_end[11:8] == $past(vde_nib);
  endproperty
  a_de_ext: assert property (p_de_ext) else $error("extended display end nibble wrong");
  property p_ext_ignored;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ext_mode == CRX_COMPAT) |=>
      (o_sync_start[11:10] == 2'b00) && (o_blank_start[11:10] == 2'b00);
  endproperty
  a_ext_ignored: assert property (p_ext_ignored) else $error("extension bits used in compat mode");
  property p_vs_line;
    @(posedge i_clk) disable iff (!i_rst_n)
    o_vsync_begin |-> (o_line == o_sync_start);
  endproperty
  a_vs_line: assert property (p_vs_line) else $error("vsync began on wrong line");
  property p_vb_line;
    @(posedge i_clk) disable iff (!i_rst_n)
    o_vblank_begin |-> (o_line == o_blank_start);
  endproperty
  a_vb_line: assert property (p_vb_line) else $error("vblank began on wrong line");
  property p_line_zero;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_frame_restart |=> (o_line == 12'h000);
  endproperty
  a_line_zero: assert property (p_line_zero) else $error("frame restart did not give line zero");
  property p_xfer_load;
    @(posedge i_clk) disable iff (!i_rst_n)
    xfer |=> (o_start_addr == $past(sa_ext)) && (!req || $past(wr_sa));
  endproperty
  a_xfer_load: assert property (p_xfer_load) else $error("start address load or request clear wrong");
  property p_addr_stable;
    @(posedge i_clk) disable iff (!i_rst_n)
    !vs_hit |=> $stable(o_start_addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("start address moved between vsyncs");
  property p_req_compat;
    @(posedge i_clk) disable iff (!i_rst_n)
    ((i_ext_mode == CRX_COMPAT) && req && !wr_sa) |=> req;
  endproperty
  a_req_compat: assert property (p_req_compat) else $error("request acted on in compat mode");
  property p_ofs_compat;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ext_mode == CRX_COMPAT) |=>
      o_row_offset == {4'h0, $past(i_row_offset_low_byte)};
  endproperty
  a_ofs_compat: assert property (p_ofs_compat) else $error("compat row offset wrong");

  c_xfer: cover property (@(posedge i_clk) disable iff (!i_rst_n) xfer);
  c_vsync: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_vsync_begin);
  c_vblank: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_vblank_begin);
  c_compat_load: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    vs_hit && (i_ext_mode == CRX_COMPAT));

endmodule : crx_ext

/* crx_disp_model.sv */
// Purpose: far-side pacing of the crtc extension, one line tick per scan line
// Assumes: fixed line length and fixed frame height
// Notes: frame restart replaces the tick on the last line of a frame
`timescale 1ns/100ps
module crx_disp_model #(
  parameter int CYC_PER_LINE = 4,
  parameter int TOTAL_LINES = 30
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  output logic o_line_tick,
  output logic o_frame_restart
);
  int cyc;
  int line;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cyc <= 0;
      line <= 0;
      o_line_tick <= 1'b0;
      o_frame_restart <= 1'b0;
    end else begin
      o_line_tick <= 1'b0;
      o_frame_restart <= 1'b0;
      cyc <= (cyc == CYC_PER_LINE - 1) ? 0 : cyc + 1;
      if (cyc == CYC_PER_LINE - 1) begin
        if (line == TOTAL_LINES - 1) begin
          // short frame keeps runs brief; first active line comes back as zero
          o_frame_restart <= 1'b1;
          line <= 0;
        end else begin
          o_line_tick <= 1'b1;
          line <= line + 1;
        end
      end
    end
  end
endmodule : crx_disp_model

/* crx_ext_tb_top.sv */
// Purpose: self-checking bench of the crtc vertical and start address extension
// Assumes: colour port pair, 30-line frames of 4 clocks a line
// Notes: expected values are assembled here from the base bytes and nibbles
`timescale 1ns/100ps
`include "crx_params.svh"
module crx_ext_tb_top;
  import crx_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0, io_rd = 1'b0, dword = 1'b0;
  logic [7:0] io_wdata = 8'h00, rdata;
  crx_mode_t ext_mode = CRX_COMPAT;
  logic [7:0] de_lo = 8'h00, ovf = 8'h00, ss_lo = 8'h00, bs_lo = 8'h00;
  logic [7:0] maxscan = 8'h00, sa_hi = 8'h00, sa_lo = 8'h00, ofs_lo = 8'h00;
  logic tick, restart, vdisp, vs_begin, vb_begin;
  crx_line_t line, de, ss, bs;
  crx_addr_t saddr;
  crx_ofs_t ofs;
  logic [13:0] pitch;
  int fails = 0, cmp_count = 0, cycles = 0;
  logic [7:0] idx [5] = '{`CRX_IDX_VDE_HI, `CRX_IDX_VSS_HI, `CRX_IDX_VBS_HI, `CRX_IDX_SA_UPD, `CRX_IDX_OFS_HI};
  logic [3:0] nib [5] = '{4'ha, 4'hb, 4'hc, 4'h3, 4'h5};

  always #25 i_clk = ~i_clk;

  crx_ext i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_io_addr(io_addr), .i_io_wr(io_wr), .i_io_rd(io_rd),
    .i_io_wdata(io_wdata), .o_io_rdata(rdata), .i_ext_mode(ext_mode), .i_display_end_low_byte(de_lo),
    .i_vertical_overflow_bits(ovf), .i_sync_start_low_byte(ss_lo), .i_blank_start_low_byte(bs_lo),
    .i_max_scan_line_reg(maxscan), .i_start_address_high_byte(sa_hi), .i_start_address_low_byte(sa_lo),
    .i_row_offset_low_byte(ofs_lo), .i_offset_dword(dword), .i_line_tick(tick), .i_frame_restart(restart),
    .o_line(line), .o_vdisp_active(vdisp), .o_vsync_begin(vs_begin), .o_vblank_begin(vb_begin),
    .o_display_end(de), .o_sync_start(ss), .o_blank_start(bs), .o_start_addr(saddr), .o_row_offset(ofs),
    .o_row_pitch_bytes(pitch));
  crx_disp_model i_disp (.i_clk(i_clk), .i_rst_n(i_rst_n), .o_line_tick(tick), .o_frame_restart(restart));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_sim();
    if (fails == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [19:0] exp, input logic [19:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic io_put(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge i_clk);
    io_wr <= 1'b0;
  endtask : io_put

  task automatic reg_wr(input logic [7:0] i, input logic [7:0] d);
    io_put(`CRX_IO_IDX_COL, i);
    io_put(`CRX_IO_DAT_COL, d);
  endtask : reg_wr

  task automatic port_chk(input string name, input logic [15:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge i_clk);
    io_rd <= 1'b0;
    @(posedge i_clk);
    #1 chk(name, exp, rdata);
  endtask : port_chk

  task automatic reg_chk(input string name, input logic [7:0] i, input logic [7:0] exp);
    io_put(`CRX_IO_IDX_COL, i);
    port_chk(name, `CRX_IO_DAT_COL, exp);
  endtask : reg_chk

  // which: 0 vsync pulse, 1 vblank pulse, 2 line zero
  task automatic wait_for(input int which);
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while (n < 600 && !((which == 0 && vs_begin === 1'b1) || (which == 1 && vb_begin === 1'b1) ||
                            (which == 2 && line === 12'h000)));
    if (n >= 600) chk("wait", 20'h1, 20'h0);
  endtask : wait_for

  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      end_sim();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      reg_chk("ext_rst", idx[k], 8'h00);
      reg_wr(idx[k], {4'h0, nib[k]});
      reg_chk("ext_rw", idx[k], {4'h0, nib[k]});
    end
    reg_wr(8'h30, 8'h05);
    reg_chk("unmapped", 8'h30, 8'h00);
    // index port reads back the index; the mono port pair reaches the same registers
    port_chk("idx_rd", `CRX_IO_IDX_COL, 8'h30);
    io_put(`CRX_IO_IDX_MONO, `CRX_IDX_OFS_HI);
    io_put(`CRX_IO_DAT_MONO, 8'h06);
    reg_chk("mono_wr", `CRX_IDX_OFS_HI, 8'h06);
    port_chk("mono_rd", `CRX_IO_DAT_MONO, 8'h06);
    reg_wr(`CRX_IDX_OFS_HI, {4'h0, nib[4]});
    @(posedge i_clk);
    de_lo <= 8'h12;
    ss_lo <= 8'h34;
    bs_lo <= 8'h56;
    ovf <= 8'h82;
    maxscan <= 8'h20;
    ofs_lo <= 8'h9c;
    repeat (3) @(posedge i_clk);
    #1 chk("de_c", {ovf[6], ovf[1], de_lo}, de);
    chk("ss_c", {ovf[7], ovf[2], ss_lo}, ss);
    chk("bs_c", {maxscan[5], ovf[3], bs_lo}, bs);
    chk("ofs_c", ofs_lo, ofs);
    chk("pitch_w", {ofs_lo, 1'b0}, pitch);
    @(posedge i_clk);
    ext_mode <= CRX_EXT;
    dword <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1 chk("de_x", {nib[0], de_lo}, de);
    chk("ss_x", {nib[1], ss_lo}, ss);
    chk("bs_x", {nib[2], bs_lo}, bs);
    chk("ofs_x", {nib[4], ofs_lo}, ofs);
    chk("pitch_d", {nib[4], ofs_lo, 2'b00}, pitch);
    // small compare values so the 30-line frame reaches them
    for (int k = 0; k < 3; k++) reg_wr(idx[k], 8'h00);
    @(posedge i_clk);
    de_lo <= 8'h0f;
    ss_lo <= 8'h14;
    bs_lo <= 8'h12;
    ovf <= 8'h00;
    maxscan <= 8'h00;
    sa_hi <= 8'h34;
    sa_lo <= 8'h56;
    wait_for(2);
    chk("vdisp_on", 20'h1, vdisp);
    reg_wr(`CRX_IDX_SA_UPD, 8'h87);
    wait_for(1);
    chk("vb_line", 20'h012, line);
    chk("vdisp_off", 20'h0, vdisp);
    chk("sa_hold", 20'h0, saddr);
    wait_for(0);
    chk("vs_line", 20'h014, line);
    chk("sa_ext", 20'h73456, saddr);
    reg_chk("req_clr", `CRX_IDX_SA_UPD, 8'h07);
    @(posedge i_clk);
    sa_hi <= 8'h99;
    wait_for(0);
    chk("sa_frame", 20'h73456, saddr);
    @(posedge i_clk);
    ext_mode <= CRX_COMPAT;
    reg_wr(`CRX_IDX_SA_UPD, 8'h81);
    wait_for(0);
    chk("sa_compat", {4'h0, sa_hi, sa_lo}, saddr);
    reg_chk("req_kept", `CRX_IDX_SA_UPD, 8'h81);
    end_sim();
  end
endmodule : crx_ext_tb_top
